/* rtl/scg_consts.svh */
`ifndef SCG_CONSTS_SVH
`define SCG_CONSTS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define SCG_IDX_GEN 10'h000
`define SCG_IDX_ANA_A 10'h001
`define SCG_IDX_ANA_B 10'h002
`define SCG_IDX_DIG_C 10'h003
`define SCG_IDX_DIG_D 10'h004
`define SCG_IDX_DIG_E 10'h005
`define SCG_IDX_DIG_F 10'h006
`define SCG_IDX_SLEEP 10'h008
`define SCG_IDX_STATUS 10'h009
`define SCG_NUM_GATE 7

// ---------------------------------------------------------------
// Writable bit masks; reserved bits store nothing and read zero
// ---------------------------------------------------------------
`define SCG_MASK_SLEEP 8'h0f
`define SCG_MASK_GEN 8'h5f
`define SCG_MASK_ANA 8'h07
`define SCG_MASK_DIG 8'h7f
`define SCG_RESET_GATE 8'h00
`define SCG_RESET_SLEEP 8'h00

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define SCG_SLEEP_ALLOW_BIT 0
`define SCG_MODE_LSB 1
`define SCG_MODE_MSB 3
`define SCG_GEN_USB 6
`define SCG_GEN_AES 4
`define SCG_GEN_EBI 3
`define SCG_GEN_RTC 2
`define SCG_GEN_EVT 1
`define SCG_GEN_DMA 0
`define SCG_ANA_DAC 2
`define SCG_ANA_ADC 1
`define SCG_ANA_CMP 0
`define SCG_DIG_TWI 6
`define SCG_DIG_SER1 5
`define SCG_DIG_SER0 4
`define SCG_DIG_SPI 3
`define SCG_DIG_FINE 2
`define SCG_DIG_TMR1 1
`define SCG_DIG_TMR0 0

// ---------------------------------------------------------------
// Sleep mode codes
// ---------------------------------------------------------------
`define SCG_MODE_HALT 3'h0
`define SCG_MODE_DEEP 3'h2
`define SCG_MODE_DEEP_CNT 3'h3
`define SCG_MODE_OSC 3'h6
`define SCG_MODE_OSC_CNT 3'h7

// ---------------------------------------------------------------
// Wake source vector positions
// ---------------------------------------------------------------
`define SCG_WAKE_ANY 0
`define SCG_WAKE_TWI 1
`define SCG_WAKE_PORT 2
`define SCG_WAKE_USB 3
`define SCG_WAKE_RTC 4
`define SCG_WAKE_N 5

`endif

/* rtl/scg_pkg.sv */
package scg_pkg;

  // Sleep sequencer states
  typedef enum logic [0:0] {
    SCG_AWAKE,
    SCG_ASLEEP
  } scg_state_t;

  // Analog port clock enables
  typedef struct packed {
    logic dac;
    logic adc;
    logic comparator_gate;
  } scg_ana_en_t;

  // Digital port clock enables
  typedef struct packed {
    logic two_wire_gate;
    logic serial1_gate;
    logic serial0_gate;
    logic spi;
    logic fine_resolution_gate;
    logic timer1_gate;
    logic timer0_gate;
  } scg_dig_en_t;

  // All peripheral clock enables
  typedef struct packed {
    logic usb;
    logic aes;
    logic external_bus_gate;
    logic rtc;
    logic event_network_gate;
    logic dma;
    scg_ana_en_t ana_a;
    scg_ana_en_t ana_b;
    scg_dig_en_t dig_c;
    scg_dig_en_t dig_d;
    scg_dig_en_t dig_e;
    scg_dig_en_t dig_f;
  } scg_clk_en_t;

  // Domain run flags
  typedef struct packed {
    logic cpu;
    logic periph;
    logic rtc;
    logic sys_osc;
    logic rtc_osc;
  } scg_domain_t;

endpackage

/* rtl/scg_top.sv */
// Implementation choice: register access over APB.
`timescale 1ns/1ps
`include "scg_consts.svh"

module scg_top
  import scg_pkg::*;
(
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU, DMA and RTC status, same clock
  input wire logic sleep_instr,
  input wire logic dma_enabled,
  input wire logic rtc_enabled,
  // Wake sources, asynchronous to pclk
  input wire logic [`SCG_WAKE_N-1:0] wake_src,
  // Domain run flags, peripheral clock enables and active sleep mode
  output scg_domain_t domain_run,
  output scg_clk_en_t clk_en,
  output logic [2:0] sleep_mode_active
);

  // -------------------------------------------------------------
  // Helper functions
  // -------------------------------------------------------------

  // Writable mask of a gate register by index
  function automatic logic [7:0] gate_mask(input logic [9:0] idx);
    logic [7:0] m;
    m = 8'h00;
    if (idx == `SCG_IDX_GEN) begin
      m = `SCG_MASK_GEN;
    end else if (idx == `SCG_IDX_ANA_A || idx == `SCG_IDX_ANA_B) begin
      m = `SCG_MASK_ANA;
    end else if (idx <= `SCG_IDX_DIG_F) begin
      m = `SCG_MASK_DIG;
    end
    return m;
  endfunction

  // Analog enables from a gate byte and the domain flag
  function automatic scg_ana_en_t ana_en(input logic [7:0] g,
                                         input logic run);
    scg_ana_en_t e;
    e.dac = run & ~g[`SCG_ANA_DAC];
    e.adc = run & ~g[`SCG_ANA_ADC];
    e.comparator_gate = run & ~g[`SCG_ANA_CMP];
    return e;
  endfunction

  // Digital enables from a gate byte and the domain flag
  function automatic scg_dig_en_t dig_en(input logic [7:0] g,
                                         input logic run);
    scg_dig_en_t e;
    e.two_wire_gate = run & ~g[`SCG_DIG_TWI];
    e.serial1_gate = run & ~g[`SCG_DIG_SER1];
    e.serial0_gate = run & ~g[`SCG_DIG_SER0];
    e.spi = run & ~g[`SCG_DIG_SPI];
    e.fine_resolution_gate = run & ~g[`SCG_DIG_FINE];
    e.timer1_gate = run & ~g[`SCG_DIG_TMR1];
    e.timer0_gate = run & ~g[`SCG_DIG_TMR0];
    return e;
  endfunction

  // Which domains a mode keeps running while asleep
  function automatic scg_domain_t mode_domains(input logic [2:0] md);
    scg_domain_t d;
    d = '0;
    case (md)
      `SCG_MODE_HALT: begin
        d.periph = 1'b1;
        d.rtc = 1'b1;
        d.sys_osc = 1'b1;
        d.rtc_osc = 1'b1;
      end
      `SCG_MODE_DEEP: begin
        d = '0;
      end
      `SCG_MODE_DEEP_CNT: begin
        d.rtc = 1'b1;
        d.rtc_osc = 1'b1;
      end
      `SCG_MODE_OSC: begin
        d.sys_osc = 1'b1;
      end
      `SCG_MODE_OSC_CNT: begin
        d.rtc = 1'b1;
        d.sys_osc = 1'b1;
        d.rtc_osc = 1'b1;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // -------------------------------------------------------------
  // State
  // -------------------------------------------------------------
  logic [7:0] gate_r [0:`SCG_NUM_GATE-1];
  logic [7:0] sleep_ctl_r;
  scg_state_t state_r;
  scg_state_t state_nxt;
  logic [2:0] act_mode_r;
  logic [`SCG_WAKE_N-1:0] wake_s1_r;
  logic [`SCG_WAKE_N-1:0] wake_s2_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  scg_domain_t domain_r;
  scg_clk_en_t clk_en_r;
  logic [2:0] sleep_mode_r;

  // -------------------------------------------------------------
  // APB decode
  // -------------------------------------------------------------
  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire is_gate = aligned && (idx <= `SCG_IDX_DIG_F);
  wire is_sleep = aligned && (idx == `SCG_IDX_SLEEP);
  wire is_status = aligned && (idx == `SCG_IDX_STATUS);
  wire mapped = is_gate | is_sleep | is_status;
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_r;
  wire wr_en = access & pwrite & mapped;
  wire [2:0] gidx = idx[2:0];
  wire [7:0] wmask = gate_mask(idx);
  wire [7:0] gate_rd = is_gate ? gate_r[gidx] : 8'h00;

  // Read data: reserved bits are never stored, so they read zero
  // reserved read zero
  wire [31:0] rd_word = is_gate ? {24'h000000, gate_rd & wmask} :
                        is_sleep ? {24'h000000,
                                    sleep_ctl_r & `SCG_MASK_SLEEP} :
                        is_status ? {24'h000000, 3'h0, act_mode_r,
                                     dma_enabled,
                                     (state_r == SCG_ASLEEP)} :
                        32'h00000000;

  // -------------------------------------------------------------
  // Write data shaping
  // -------------------------------------------------------------

  // Refuse a DMA gate set while the controller runs
  // DMA gate guard
  wire dma_block = (idx == `SCG_IDX_GEN) & dma_enabled &
                   ~gate_r[0][`SCG_GEN_DMA];
  wire [7:0] gate_wdata = (pwdata[7:0] & wmask) &
                          ~{7'h00, dma_block};
  wire [7:0] sleep_wdata = pwdata[7:0] & `SCG_MASK_SLEEP;

  // -------------------------------------------------------------
  // Sleep sequencer
  // -------------------------------------------------------------
  wire sleep_allow = sleep_ctl_r[`SCG_SLEEP_ALLOW_BIT];
  wire [2:0] sleep_mode_select =
    sleep_ctl_r[`SCG_MODE_MSB:`SCG_MODE_LSB];

  // Reserved codes are treated as no valid mode and never sleep
  // mode decode
  wire mode_valid = (sleep_mode_select == `SCG_MODE_HALT) ||
                    (sleep_mode_select == `SCG_MODE_DEEP) ||
                    (sleep_mode_select == `SCG_MODE_DEEP_CNT) ||
                    (sleep_mode_select == `SCG_MODE_OSC) ||
                    (sleep_mode_select == `SCG_MODE_OSC_CNT);
  // allow bit gates entry
  // A sleep instruction seen while already asleep must not re-pick a mode
  wire enter = sleep_instr & sleep_allow & mode_valid &
               (state_r == SCG_AWAKE);

  // Wake qualification per active mode
  wire w_any = wake_s2_r[`SCG_WAKE_ANY];
  wire w_async = wake_s2_r[`SCG_WAKE_TWI] |
                 wake_s2_r[`SCG_WAKE_PORT] |
                 wake_s2_r[`SCG_WAKE_USB];
  wire w_rtc = wake_s2_r[`SCG_WAKE_RTC] & rtc_enabled;
  wire cnt_mode = (act_mode_r == `SCG_MODE_DEEP_CNT) ||
                  (act_mode_r == `SCG_MODE_OSC_CNT);
  wire wake = (act_mode_r == `SCG_MODE_HALT) ? (w_any | w_async) :
              (w_async | (cnt_mode & w_rtc));

  // Next state of the sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SCG_AWAKE: begin
        if (enter) begin
          state_nxt = SCG_ASLEEP;
        end
      end
      SCG_ASLEEP: begin
        if (wake) begin
          state_nxt = SCG_AWAKE;
        end
      end
      default: begin
        state_nxt = SCG_AWAKE;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Domain and clock enable computation
  // -------------------------------------------------------------

  // Awake runs every domain; asleep runs what the mode keeps
  wire scg_domain_t dom_nxt = (state_nxt == SCG_AWAKE) ?
                              5'b11111 :
                              mode_domains(enter ? sleep_mode_select :
                                           act_mode_r);
  wire pr = dom_nxt.periph;

  // Per-peripheral enables: domain run and not gated
  // USB gate
  wire scg_clk_en_t en_nxt = {
    pr & ~gate_r[0][`SCG_GEN_USB],
    pr & ~gate_r[0][`SCG_GEN_AES],
    pr & ~gate_r[0][`SCG_GEN_EBI],
    dom_nxt.rtc & ~gate_r[0][`SCG_GEN_RTC],
    pr & ~gate_r[0][`SCG_GEN_EVT],
    pr & ~gate_r[0][`SCG_GEN_DMA],
    ana_en(gate_r[1], pr),
    ana_en(gate_r[2], pr),
    dig_en(gate_r[3], pr),
    dig_en(gate_r[4], pr),
    dig_en(gate_r[5], pr),
    dig_en(gate_r[6], pr)
  };

  // -------------------------------------------------------------
  // Wake synchroniser
  // -------------------------------------------------------------

  // Wake pins are asynchronous; only the second stage is used
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_s1_r <= '0;
      wake_s2_r <= '0;
    end else begin
      wake_s1_r <= wake_src;
      wake_s2_r <= wake_s1_r;
    end
  end

  // -------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------

  // Gate registers; write lands only on the access edge
  // gate block indices
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `SCG_NUM_GATE; i++) begin
        gate_r[i] <= `SCG_RESET_GATE;
      end
    end else if (wr_en && is_gate) begin
      gate_r[gidx] <= gate_wdata;
    end
  end

  // Sleep control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_ctl_r <= `SCG_RESET_SLEEP;
    end else if (wr_en && is_sleep) begin
      sleep_ctl_r <= sleep_wdata;
    end
  end

  // Sequencer state and the mode captured at entry
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= SCG_AWAKE;
      act_mode_r <= `SCG_MODE_HALT;
    end else begin
      state_r <= state_nxt;
      if (enter && state_r == SCG_AWAKE) begin
        act_mode_r <= sleep_mode_select;
      end
    end
  end

  // Registered outputs; enables change only on clock edges, so
  // peripherals see no runt pulses
  // glitch-free enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      domain_r <= '1;
      clk_en_r <= '1;
      sleep_mode_r <= `SCG_MODE_HALT;
    end else begin
      domain_r <= dom_nxt;
      clk_en_r <= en_nxt;
      sleep_mode_r <= (state_nxt == SCG_ASLEEP) ?
                      (enter ? sleep_mode_select : act_mode_r) :
                      `SCG_MODE_HALT;
    end
  end

  // APB answer: one wait-free access phase after each setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= setup;
      if (setup) begin
        pslverr_r <= ~mapped;
        prdata_r <= pwrite ? 32'h00000000 : rd_word;
      end else begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
      end
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign domain_run = domain_r;
  assign clk_en = clk_en_r;
  assign sleep_mode_active = sleep_mode_r;

endmodule

/* verif/scg_checker.sv */
`timescale 1ns/1ps
`include "scg_consts.svh"
// ---------------------------------------------------------------
// Port-level checks
// ---------------------------------------------------------------
module scg_checker
  import scg_pkg::*;
(
  // APB side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic sleep_instr,
  input wire logic dma_enabled,
  input wire logic rtc_enabled,
  input wire logic [`SCG_WAKE_N-1:0] wake_src,
  input wire scg_domain_t domain_run,
  input wire scg_clk_en_t clk_en,
  input wire logic [2:0] sleep_mode_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] slp_r;
  // Address decode and the mode held in the mirror
  wire [9:0] idx = paddr[11:2];
  wire bad = idx == 10'h007 || idx > 10'h009 || paddr[1:0] != 2'h0;
  wire [2:0] mode = slp_r[3:1];
  wire ok_mode = !(mode == 3'h1 || mode == 3'h4 || mode == 3'h5);
  wire [7:0] rmask = idx == `SCG_IDX_GEN ? `SCG_MASK_GEN :
                     idx < 10'h003 ? `SCG_MASK_ANA : `SCG_MASK_DIG;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable && pready;
  endsequence
  // Mirror of sleep control; entry cannot be judged from pins alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      slp_r <= 4'h0;
    else if (psel && penable && pready && pwrite
             && idx == `SCG_IDX_SLEEP)
      slp_r <= pwdata[3:0];
  end
  // Domains that each sleep mode keeps, {periph,rtc,sys,rtc_osc}
  function automatic logic [3:0] f_dom(input logic [2:0] m);
    case (m)
      `SCG_MODE_HALT: f_dom = 4'hf;
      `SCG_MODE_DEEP_CNT: f_dom = 4'h5;
      `SCG_MODE_OSC: f_dom = 4'h2;
      `SCG_MODE_OSC_CNT: f_dom = 4'h7;
      default: f_dom = 4'h0;
    endcase
  endfunction
  AST_READY_NEXT:
    assert property (s_setup |=> s_acc) else $error("no ready");
  AST_READY_PULSE:
    assert property (pready |=> !pready) else $error("ready held");
  AST_SLVERR_MAP:
    assert property (s_setup ##0 bad |=> pslverr)
    else $error("unmapped not refused");
  AST_RSVD_ZERO:
    assert property (s_acc ##0 !pwrite && idx < 10'h007
      |-> (prdata[7:0] & ~rmask) == 8'h00 && prdata[31:8] == 24'h0)
    else $error("reserved bit read set");
  AST_USB_GATE:
    assert property (s_acc ##0 pwrite && idx == `SCG_IDX_GEN
      && pwdata[6] && domain_run.cpu && !sleep_instr
      |-> ##[1:2] !clk_en.usb) else $error("usb clock not stopped");
  AST_DMA_REFUSE:
    assert property (s_acc ##0 pwrite && idx == `SCG_IDX_GEN
      && dma_enabled && clk_en.dma && domain_run.cpu && !sleep_instr
      |-> ##1 clk_en.dma [*2]) else $error("dma gate accepted");
  AST_SLEEP_REFUSE:
    assert property (sleep_instr && domain_run.cpu
      && (!slp_r[0] || !ok_mode) |=> domain_run.cpu)
    else $error("sleep without allow");
  AST_SLEEP_ENTER:
    assert property (sleep_instr && domain_run.cpu && slp_r[0] && ok_mode
      |=> !domain_run.cpu && sleep_mode_active == $past(mode))
    else $error("sleep not entered");
  AST_MODE_DOMAINS:
    assert property (!domain_run.cpu
      |-> domain_run[3:0] == f_dom(sleep_mode_active))
    else $error("wrong domains asleep");
  AST_DEEP_OFF:
    assert property (!domain_run.cpu
      && sleep_mode_active == `SCG_MODE_DEEP
      |-> clk_en == scg_clk_en_t'(0)) else $error("clock in deep sleep");
endmodule

bind scg_top scg_checker u_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sleep_instr,
  .dma_enabled, .rtc_enabled, .wake_src, .domain_run, .clk_en,
  .sleep_mode_active);

/* verif/scg_periph_model.sv */
`timescale 1ns/1ps
// ---------------------------------------------------------------
// Peripherals fed by the gated clocks
// ---------------------------------------------------------------
module scg_periph_model
  import scg_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Gated clock enables
  input wire scg_clk_en_t clk_en,
  // Observed state
  output logic [7:0] tmr_cnt,
  output logic [7:0] evt_cnt
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_cnt <= 8'h00;
      evt_cnt <= 8'h00;
    end else begin
      if (clk_en.dig_c.timer0_gate)
        tmr_cnt <= tmr_cnt + 8'h01;
      if (clk_en.event_network_gate)
        evt_cnt <= evt_cnt + 8'h01;
    end
  end
endmodule

/* verif/sleep_and_clock_gating_tb.sv */
`timescale 1ns/1ps
`include "scg_consts.svh"
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, s); end end
module sleep_and_clock_gating_tb
  import scg_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, seed;
  logic sleep_instr, dma_enabled, rtc_enabled;
  logic [`SCG_WAKE_N-1:0] wake_src;
  scg_domain_t domain_run;
  scg_clk_en_t clk_en;
  logic [2:0] sleep_mode_active;
  logic [7:0] tmr_cnt, evt_cnt, c_t, c_e, d;
  logic [7:0] g [8];
  logic [2:0] md [5] = '{3'h0, 3'h2, 3'h3, 3'h6, 3'h7};
  logic [4:0] dm [5] = '{5'h0f, 5'h00, 5'h05, 5'h02, 5'h07};
  logic [7:0] rf [4] = '{8'h0e, 8'h03, 8'h09, 8'h0b};
  // Wake source each mode accepts, one mode per source bit
  logic [4:0] ws [5] = '{5'h01, 5'h02, 5'h10, 5'h08, 5'h04};
  int n_fail = 0, compares = 0, cyc = 0, k;
  logic [9:0] ix;

  scg_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sleep_instr, .dma_enabled,
    .rtc_enabled, .wake_src, .domain_run, .clk_en, .sleep_mode_active);
  scg_periph_model u_per (.pclk, .presetn, .clk_en, .tmr_cnt, .evt_cnt);

  // ---------------------------------------------------------------
  // Expectation helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction
  function automatic logic [7:0] f_msk(input logic [9:0] i);
    f_msk = i == 10'h000 ? 8'h5f : i < 10'h003 ? 8'h07 : 8'h7f;
  endfunction
  // A set of the DMA gate is dropped while the controller runs
  function automatic logic [7:0] f_st(input logic [9:0] i, input logic [7:0] v);
    f_st = v & f_msk(i);
    if (i == 10'h000 && dma_enabled && !g[0][0])
      f_st[0] = 1'b0;
  endfunction
  function automatic scg_clk_en_t f_en();
    f_en = scg_clk_en_t'(~{g[0][6], g[0][4:0], g[1][2:0], g[2][2:0],
      g[3][6:0], g[4][6:0], g[5][6:0], g[6][6:0]});
  endfunction

  // ---------------------------------------------------------------
  // Bus and sleep tasks
  // ---------------------------------------------------------------
  task automatic apb(input logic w, input logic [9:0] i,
      input logic [7:0] v, output logic [7:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {i, 2'h0};
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] v);
    logic [7:0] r;
    logic e;
    apb(1'b1, i, v, r, e);
    `CHK("error", (i == 10'h007), e)
    if (i < 10'h007)
      g[i] = f_st(i, v);
  endtask
  task automatic rchk(input logic [9:0] i, input logic [7:0] x);
    logic [7:0] r;
    logic e;
    apb(1'b0, i, 8'h00, r, e);
    `CHK("read", x, r)
  endtask
  task automatic slp();
    @(posedge pclk);
    sleep_instr <= 1'b1;
    @(posedge pclk);
    sleep_instr <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic finish_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Clock and a cut-off far beyond the expected run
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sleep_instr = 1'b0;
    dma_enabled = 1'b0;
    rtc_enabled = 1'b1;
    wake_src = 5'h00;
    seed = 32'hdf89;
    g = '{default: 8'h00};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    `CHK("clk_en", f_en(), clk_en)
    `CHK("domains", 5'h1f, domain_run)
    // Every writable bit set; reserved bits must still read zero
    // reserved bits written zero
    for (k = 0; k < 7; k++) begin
      rchk(10'(k), 8'h00);
      wr(10'(k), f_msk(10'(k)));
      rchk(10'(k), g[k]);
    end
    // Random gate traffic, index 7 is the unmapped hole
    // reserved bits masked off
    repeat (40) begin
      seed = xs(seed);
      dma_enabled <= seed[8];
      ix = {7'h0, seed[2:0]};
      d = seed[23:16] & f_msk(ix);
      wr(ix, d);
      rchk(ix, g[ix]);
      @(negedge pclk);
      `CHK("clk_en", f_en(), clk_en)
      @(posedge pclk);
    end
    dma_enabled <= 1'b1;
    wr(10'h000, 8'h00);
    wr(10'h000, 8'h01);
    rchk(10'h000, 8'h00);
    dma_enabled <= 1'b0;
    wr(10'h000, 8'h01);
    rchk(10'h000, 8'h01);
    // Frozen while gated; once ungated the timer advances one count per cycle
    for (k = 1; k < 7; k++)
      wr(10'(k), 8'h00);
    wr(10'h000, 8'h02);
    wr(10'h003, 8'h01);
    repeat (3) @(posedge pclk);
    c_t = tmr_cnt;
    c_e = evt_cnt;
    repeat (5) @(posedge pclk);
    `CHK("timer", c_t, tmr_cnt)
    `CHK("events", c_e, evt_cnt)
    wr(10'h000, 8'h00);
    wr(10'h003, 8'h00);
    repeat (3) @(posedge pclk);
    c_t = tmr_cnt;
    repeat (5) @(posedge pclk);
    `CHK("timer", 8'(c_t + 8'h05), tmr_cnt)
    // Every sleep mode, woken by a source that it accepts
    for (k = 0; k < 5; k++) begin
      wr(`SCG_IDX_SLEEP, {4'h0, md[k], 1'b1});
      rchk(`SCG_IDX_SLEEP, {4'h0, md[k], 1'b1});
      slp();
      `CHK("mode", md[k], sleep_mode_active)
      `CHK("domains", {1'b0, dm[k]}, domain_run)
      if (k == 0)
        `CHK("clk_en", f_en(), clk_en)
      rchk(`SCG_IDX_STATUS, {3'h0, md[k], 2'h1});
      // Sources the mode must ignore; counter wake also needs enable
      rtc_enabled <= !(k == 2 || k == 4);
      wake_src <= (k == 0) ? 5'h00 : 5'h11;
      repeat (5) @(posedge pclk);
      @(negedge pclk);
      `CHK("asleep", 1'b0, domain_run.cpu)
      @(posedge pclk);
      rtc_enabled <= 1'b1;
      wake_src <= ws[k];
      for (int t = 0; t < 10 && domain_run.cpu !== 1'b1; t++)
        @(posedge pclk);
      wake_src <= 5'h00;
      @(negedge pclk);
      `CHK("domains", 5'h1f, domain_run)
      wr(`SCG_IDX_SLEEP, 8'h00);
    end
    // Allow clear or reserved mode keeps the core awake
    for (k = 0; k < 4; k++) begin
      wr(`SCG_IDX_SLEEP, rf[k]);
      slp();
      `CHK("domains", 5'h1f, domain_run)
    end
    finish_test();
  end
endmodule
